// [hw/dag_regs.vh]
// Constants for the dual data address generator: register map, fields, widths.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
`ifndef DAG_REGS_VH
`define DAG_REGS_VH

`define DAG_ADDR_W        12
`define DAG_DM_W          32
`define DAG_PM_W          24
`define DAG_SHORT_IMM_W   6

// Mode word offset and bank select bit positions.
`define DAG_MODE_OFFSET   12'h000
`define DAG_MODE_DM_HI    3
`define DAG_MODE_DM_LO    4
`define DAG_MODE_PM_HI    5
`define DAG_MODE_PM_LO    6

// Generator register pages: byte address = page << 8 | type << 5 | number << 2.
`define DAG_PAGE_DM       4'h1
`define DAG_PAGE_PM       4'h2
`define DAG_TYPE_PTR      2'h0
`define DAG_TYPE_STEP     2'h1
`define DAG_TYPE_BASE     2'h2
`define DAG_TYPE_LEN      2'h3

`define DAG_RESP_OKAY     2'h0
`define DAG_RESP_SLVERR   2'h2

`endif

// [hw/dual_data_address_generator.v]
// Two indirect address generators with an AXI4-Lite register port.
// Assumes the instruction decoder drives request ports synchronously on aclk
// and never mixes a step of one generator with a pointer of the other.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dag_regs.vh"

// ---------------------------------------------------------------------------
// One generator: register banks, modify adder and wraparound logic
// ---------------------------------------------------------------------------
module agen_core #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Half-bank selects
  input  wire         bank_hi,
  input  wire         bank_lo,
  // Address request
  input  wire         req_valid,
  input  wire         req_pre,
  input  wire [2:0]   req_ptr,
  input  wire [2:0]   req_step,
  input  wire         req_use_imm,
  input  wire         req_short,
  input  wire [W-1:0] req_imm,
  output reg  [W-1:0] addr_reg,
  output reg          addr_valid_reg,
  // Register access
  input  wire         wr_en,
  input  wire [1:0]   wr_type,
  input  wire [2:0]   wr_n,
  input  wire [W-1:0] wr_data,
  input  wire [1:0]   rd_type,
  input  wire [2:0]   rd_n,
  output reg  [W-1:0] rd_data
);

  reg  [W-1:0] ptr_mem  [0:15];
  reg  [W-1:0] step_mem [0:15];
  reg  [W-1:0] base_mem [0:15];
  reg  [W-1:0] len_mem  [0:15];
  integer      i;

  // -------------------------------------------------------------------------
  // Register banks and index mapping
  // -------------------------------------------------------------------------
  // Bit 3 of the physical index picks the alternate copy of that half.
  function [3:0] phys;
    input [2:0] n;
    input       hi;
    input       lo;
    begin
      phys = {(n[2] ? hi : lo), n};
    end
  endfunction

  wire [3:0]   pi = phys(req_ptr, bank_hi, bank_lo);
  wire [3:0]   si = phys(req_step, bank_hi, bank_lo);
  wire [3:0]   wi = phys(wr_n, bank_hi, bank_lo);
  wire [3:0]   ri = phys(rd_n, bank_hi, bank_lo);

  // -------------------------------------------------------------------------
  // Modify adder and wraparound
  // -------------------------------------------------------------------------
  wire [W-1:0] cur     = ptr_mem[pi];
  // Short immediates from parallel-form instructions carry six bits, sign-extended.
  wire [W-1:0] imm_ext = req_short ?
                         {{(W-`DAG_SHORT_IMM_W){req_imm[`DAG_SHORT_IMM_W-1]}},
                          req_imm[`DAG_SHORT_IMM_W-1:0]} : req_imm;
  wire [W-1:0] modv    = req_use_imm ? imm_ext : step_mem[si];
  wire [W-1:0] sum     = cur + modv;
  wire [W-1:0] bbase   = base_mem[pi];
  wire [W-1:0] blen    = len_mem[pi];
  // The end bound is held one bit wider so a buffer near the top of memory
  // still compares correctly whatever its base.
  wire [W:0]   end_ext = {1'b0, bbase} + {1'b0, blen};
  wire         wrap_hi = ~modv[W-1] & ({1'b0, sum} >= end_ext);
  wire         wrap_lo = modv[W-1] & (sum < bbase);
  reg  [W-1:0] wrapped;

  always @* begin
    if (blen == {W{1'b0}}) begin
      wrapped = sum;
    end else if (wrap_hi) begin
      wrapped = sum - blen;
    end else if (wrap_lo) begin
      wrapped = sum + blen;
    end else begin
      wrapped = sum;
    end
  end

  // -------------------------------------------------------------------------
  // Register update
  // -------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        ptr_mem[i]  <= {W{1'b0}};
        step_mem[i] <= {W{1'b0}};
        base_mem[i] <= {W{1'b0}};
        len_mem[i]  <= {W{1'b0}};
      end
      addr_reg       <= {W{1'b0}};
      addr_valid_reg <= 1'b0;
    end else begin
      addr_valid_reg <= req_valid;
      // The address holds between requests so the memory bus sees a steady value.
      if (req_valid) begin
        addr_reg <= req_pre ? sum : cur;
      end
      if (req_valid && !req_pre) begin
        ptr_mem[pi] <= wrapped;
      end
      // A register write to the same pointer lands after the update and wins.
      if (wr_en) begin
        case (wr_type)
          `DAG_TYPE_PTR: begin
            ptr_mem[wi] <= wr_data;
          end
          `DAG_TYPE_STEP: begin
            step_mem[wi] <= wr_data;
          end
          `DAG_TYPE_BASE: begin
            base_mem[wi] <= wr_data;
            ptr_mem[wi]  <= wr_data;
          end
          default: begin
            len_mem[wi] <= wr_data;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // Register read
  // -------------------------------------------------------------------------
  // Reads see the bank chosen by the current mode word, like every other access.
  always @* begin
    case (rd_type)
      `DAG_TYPE_PTR: begin
        rd_data = ptr_mem[ri];
      end
      `DAG_TYPE_STEP: begin
        rd_data = step_mem[ri];
      end
      `DAG_TYPE_BASE: begin
        rd_data = base_mem[ri];
      end
      default: begin
        rd_data = len_mem[ri];
      end
    endcase
  end

endmodule

// ---------------------------------------------------------------------------
// Top: both generators, the mode word and the register bus slave
// ---------------------------------------------------------------------------
module dual_data_address_generator (
  // Clock and reset
  input  wire                     aclk,
  input  wire                     aresetn,
  // AXI4-Lite write address and data
  input  wire [`DAG_ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]               s_axi_awprot,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  // AXI4-Lite read
  input  wire [`DAG_ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]               s_axi_arprot,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  // Data-memory address request
  input  wire                     dm_req_valid,
  input  wire                     dm_req_pre,
  input  wire [2:0]               dm_req_ptr,
  input  wire [2:0]               dm_req_step,
  input  wire                     dm_req_use_imm,
  input  wire                     dm_req_short,
  input  wire [`DAG_DM_W-1:0]     dm_req_imm,
  output wire [`DAG_DM_W-1:0]     dm_addr,
  output wire                     dm_addr_valid,
  // Program-memory address request
  input  wire                     pm_req_valid,
  input  wire                     pm_req_pre,
  input  wire [2:0]               pm_req_ptr,
  input  wire [2:0]               pm_req_step,
  input  wire                     pm_req_use_imm,
  input  wire                     pm_req_short,
  input  wire [`DAG_PM_W-1:0]     pm_req_imm,
  output wire [`DAG_PM_W-1:0]     pm_addr,
  output wire                     pm_addr_valid
);

  // -------------------------------------------------------------------------
  // Register map decode
  // -------------------------------------------------------------------------
  // Decoded address: {valid, is_mode, is_pm, type[1:0], number[2:0]}.
  // Misaligned addresses and the upper half of each page are left unmapped,
  // so a stray access answers with an error instead of aliasing a register.
  function [7:0] map_addr;
    input [`DAG_ADDR_W-1:0] a;
    begin
      if (a == `DAG_MODE_OFFSET) begin
        map_addr = 8'hc0;
      end else if (a[1:0] == 2'h0 && a[7] == 1'b0 &&
                   (a[11:8] == `DAG_PAGE_DM || a[11:8] == `DAG_PAGE_PM)) begin
        map_addr = {1'b1, 1'b0, (a[11:8] == `DAG_PAGE_PM), a[6:5], a[4:2]};
      end else begin
        map_addr = 8'h00;
      end
    end
  endfunction

  reg  [3:0]             mode_reg; // Bank selects, mode bits 3 to 6.
  reg                    aw_hold_reg;
  reg                    w_hold_reg;
  reg  [`DAG_ADDR_W-1:0] aw_addr_reg;
  reg  [31:0]            w_data_reg;
  reg                    w_full_reg;

  wire [7:0] wdec     = map_addr(aw_addr_reg);
  wire [7:0] rdec     = map_addr(s_axi_araddr);
  wire       do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  // Partial-word writes are refused so a 24-bit register never takes half a word.
  wire       wr_ok    = wdec[7] & w_full_reg;
  wire       dm_wr    = do_write & wr_ok & ~wdec[6] & ~wdec[5];
  wire       pm_wr    = do_write & wr_ok & ~wdec[6] & wdec[5];
  wire       mode_wr  = do_write & wr_ok & wdec[6];

  wire [`DAG_DM_W-1:0] dm_rd;
  wire [`DAG_PM_W-1:0] pm_rd;

  agen_core #(.W(`DAG_DM_W)) dmem_address_generator (
    .aclk           (aclk),
    .aresetn        (aresetn),
    // The mode word keeps bits 6 to 3, so each select sits three places lower.
    .bank_hi        (mode_reg[`DAG_MODE_DM_HI-3]),
    .bank_lo        (mode_reg[`DAG_MODE_DM_LO-3]),
    .req_valid      (dm_req_valid),
    .req_pre        (dm_req_pre),
    .req_ptr        (dm_req_ptr),
    .req_step       (dm_req_step),
    .req_use_imm    (dm_req_use_imm),
    .req_short      (dm_req_short),
    .req_imm        (dm_req_imm),
    .addr_reg       (dm_addr),
    .addr_valid_reg (dm_addr_valid),
    .wr_en          (dm_wr),
    .wr_type        (wdec[4:3]),
    .wr_n           (wdec[2:0]),
    .wr_data        (w_data_reg),
    .rd_type        (rdec[4:3]),
    .rd_n           (rdec[2:0]),
    .rd_data        (dm_rd)
  );

  agen_core #(.W(`DAG_PM_W)) pmem_address_generator (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .bank_hi        (mode_reg[`DAG_MODE_PM_HI-3]),
    .bank_lo        (mode_reg[`DAG_MODE_PM_LO-3]),
    .req_valid      (pm_req_valid),
    .req_pre        (pm_req_pre),
    .req_ptr        (pm_req_ptr),
    .req_step       (pm_req_step),
    .req_use_imm    (pm_req_use_imm),
    .req_short      (pm_req_short),
    .req_imm        (pm_req_imm),
    .addr_reg       (pm_addr),
    .addr_valid_reg (pm_addr_valid),
    .wr_en          (pm_wr),
    .wr_type        (wdec[4:3]),
    .wr_n           (wdec[2:0]),
    .wr_data        (w_data_reg[`DAG_PM_W-1:0]),
    .rd_type        (rdec[4:3]),
    .rd_n           (rdec[2:0]),
    .rd_data        (pm_rd)
  );

  // ---------------------------------------------------------------------------
  // Write channels
  // ---------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DAG_RESP_OKAY;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= {`DAG_ADDR_W{1'b0}};
      w_data_reg    <= 32'h0000_0000;
      w_full_reg    <= 1'b0;
      mode_reg      <= 4'h0;
    end else begin
      // Address and data are held apart, so the master may offer them in either order.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_hold_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_full_reg   <= (s_axi_wstrb == 4'hf);
        s_axi_wready <= 1'b0;
      end else if (!w_hold_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DAG_RESP_OKAY : `DAG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (mode_wr) begin
        mode_reg <= w_data_reg[`DAG_MODE_PM_LO:`DAG_MODE_DM_HI];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read channels
  // ---------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DAG_RESP_OKAY;
    // Read data is captured at the address handshake and then held,
    // so the answer never changes while the master keeps rready low.
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= rdec[7] ? `DAG_RESP_OKAY : `DAG_RESP_SLVERR;
      if (!rdec[7]) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (rdec[6]) begin
        s_axi_rdata <= {25'h0000000, mode_reg, 3'h0};
      end else if (rdec[5]) begin
        s_axi_rdata <= {8'h00, pm_rd};
      end else begin
        s_axi_rdata <= dm_rd;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [tb/dag_properties.sv]
// Checker for the address generator top: bus handshakes and request timing.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
module dag_properties (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Address requests
  input wire        dm_req_valid,
  input wire        dm_req_pre,
  input wire [2:0]  dm_req_ptr,
  input wire        dm_req_use_imm,
  input wire        dm_req_short,
  input wire [31:0] dm_req_imm,
  input wire [31:0] dm_addr,
  input wire        dm_addr_valid,
  input wire        pm_req_valid,
  input wire        pm_addr_valid
);
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  wire pre_imm = dm_req_valid && dm_req_pre && dm_req_use_imm && !dm_req_short;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("second write taken early");
  dm_answer_a: assert property (dm_req_valid |=> dm_addr_valid)
    else $error("data address not produced");
  dm_quiet_a: assert property (!dm_req_valid |=> !dm_addr_valid && $stable(dm_addr))
    else $error("data address moved without request");
  pm_answer_a: assert property (pm_req_valid |=> pm_addr_valid)
    else $error("program address not produced");
  // Two pre-modify reads of one pointer differ by exactly the immediates.
  pre_keep_a: assert property (pre_imm ##1 !dm_req_valid ##1 (pre_imm &&
      dm_req_ptr == $past(dm_req_ptr, 2)) |=>
      dm_addr - $past(dm_addr) == $past(dm_req_imm) - $past(dm_req_imm, 3))
    else $error("pre-modify changed the pointer");
endmodule

// [tb/decoder_model.sv]
// Instruction decoder stand-in: one address request per call, and the
// address that comes back. Assumes the shared fields feed both generators.
`timescale 1ns/1ps
module decoder_model (
  // Clock
  input wire        aclk,
  // Requests
  output reg        dm_valid,
  output reg        pm_valid,
  output reg        pre,
  output reg [2:0]  ptr,
  output reg [2:0]  step,
  output reg        use_imm,
  output reg        short_imm,
  output reg [31:0] imm,
  // Address outputs
  input wire [31:0] dm_addr,
  input wire        dm_addr_valid,
  input wire [23:0] pm_addr,
  input wire        pm_addr_valid
);
  initial {dm_valid, pm_valid, pre, ptr, step, use_imm, short_imm, imm} = 0;
  task issue(input g, input p, input [2:0] pt, input [2:0] st, input ui, input sh,
             input [31:0] im, output [31:0] a, output v);
    begin
      @(posedge aclk);
      dm_valid <= !g;
      pm_valid <= g;
      {pre, ptr, step, use_imm, short_imm, imm} <= {p, pt, st, ui, sh, im};
      @(posedge aclk);
      dm_valid <= 1'b0;
      pm_valid <= 1'b0;
      #1;
      a = g ? {8'h00, pm_addr} : dm_addr;
      v = g ? pm_addr_valid : dm_addr_valid;
    end
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench: register bus, address requests, circular buffers, banks.
// Assumes hw/ is on the include path.
`timescale 1ns/1ps
`include "dag_regs.vh"
module tb;
  reg         aclk;
  reg         aresetn;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata;
  reg         awvalid, wvalid, bready, arvalid, rready;
  reg         slow;
  reg  [3:0]  wstrb;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata, imm, dma;
  wire        dmv, pmv, pre, uim, shi, dav, pav;
  wire [2:0]  ptr, stp;
  wire [23:0] pma;
  integer     err_total, cmp_count, cyc;
  localparam [1:0] OK = `DAG_RESP_OKAY;
  localparam [1:0] ER = `DAG_RESP_SLVERR;
  dual_data_address_generator u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dm_req_valid(dmv), .dm_req_pre(pre), .dm_req_ptr(ptr), .dm_req_step(stp),
    .dm_req_use_imm(uim), .dm_req_short(shi), .dm_req_imm(imm), .dm_addr(dma),
    .dm_addr_valid(dav), .pm_req_valid(pmv), .pm_req_pre(pre), .pm_req_ptr(ptr),
    .pm_req_step(stp), .pm_req_use_imm(uim), .pm_req_short(shi),
    .pm_req_imm(imm[23:0]), .pm_addr(pma), .pm_addr_valid(pav));
  decoder_model u_dec (.aclk(aclk), .dm_valid(dmv), .pm_valid(pmv), .pre(pre),
    .ptr(ptr), .step(stp), .use_imm(uim), .short_imm(shi), .imm(imm),
    .dm_addr(dma), .dm_addr_valid(dav), .pm_addr(pma), .pm_addr_valid(pav));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // -----------------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------------
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  function [11:0] ra(input g, input [1:0] t, input [2:0] n);
    ra = {g ? `DAG_PAGE_PM : `DAG_PAGE_DM, 1'b0, t, n, 2'b00};
  endfunction
  // Expected write-back of a circular post-modify.
  function [31:0] nxt(input [31:0] p, input [31:0] m, input [31:0] b, input [31:0] l);
    reg [31:0] s;
    begin
      s = p + m;
      if (!m[31] && {1'b0, s} >= {1'b0, b} + {1'b0, l}) nxt = s - l;
      else if (m[31] && s < b) nxt = s + l;
      else nxt = s;
    end
  endfunction
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    reg ad, wd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 2'b11, !slow};
      while (!(ad && wd)) begin
        @(posedge aclk);
        if (awvalid && awready) begin
          ad = 1'b1;
          awvalid <= 1'b0;
        end
        if (wvalid && wready) begin
          wd = 1'b1;
          wvalid <= 1'b0;
        end
      end
      while (!bvalid) @(posedge aclk);
      if (!bready) begin
        bready <= 1'b1;
        @(posedge aclk);
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 1'b1, !slow};
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      if (!rready) begin
        rready <= 1'b1;
        @(posedge aclk);
      end
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
    end
  endtask
  task rq(input g, input p, input [2:0] pt, input [2:0] st, input ui, input sh,
          input [31:0] im, input [31:0] ea);
    reg [31:0] a;
    reg        v;
    begin
      u_dec.issue(g, p, pt, st, ui, sh, im, a, v);
      chk({31'h0, v}, 32'h1);
      chk(a, ea);
    end
  endtask
  // -----------------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------------
  task t_reg;
    begin
      rd(`DAG_MODE_OFFSET, 32'h0, OK);
      rd(ra(1, 3, 7), 32'h0, OK);
      rd(12'h300, 32'h0, ER);
      wr(12'h304, 32'h1, ER);
      wstrb <= 4'h3;
      wr(ra(0, 1, 4), 32'h9, ER);
      wstrb <= 4'hf;
      rd(ra(0, 1, 4), 32'h0, OK);
      wr(ra(0, 2, 3), 32'hfedcba98, OK);
      rd(ra(0, 0, 3), 32'hfedcba98, OK);
      wr(ra(0, 0, 3), 32'h55, OK);
      rd(ra(0, 2, 3), 32'hfedcba98, OK);
      rd(ra(0, 0, 3), 32'h55, OK);
      wr(ra(1, 0, 1), 32'hab123456, OK);
      rd(ra(1, 0, 1), 32'h123456, OK);
    end
  endtask
  task t_circ;
    integer    i;
    reg [31:0] p;
    begin
      wr(ra(0, 3, 0), 32'd11, OK);
      wr(ra(0, 2, 0), 32'h103, OK);
      wr(ra(0, 1, 1), 32'h4, OK);
      p = 32'h103;
      for (i = 0; i < 9; i = i + 1) begin
        rq(0, 0, 0, 1, 0, 0, 32'h0, p);
        p = nxt(p, 32'h4, 32'h103, 32'd11);
      end
      for (i = 0; i < 4; i = i + 1) begin
        rq(0, 0, 0, 0, 1, 0, 32'hfffffffb, p);
        p = nxt(p, 32'hfffffffb, 32'h103, 32'd11);
      end
      rd(ra(0, 0, 0), p, OK);
      rq(0, 1, 0, 0, 1, 0, 32'h40, p + 32'h40);
      rq(0, 1, 0, 0, 1, 0, 32'h44, p + 32'h44);
      rq(0, 1, 0, 0, 1, 1, 32'h3e, p - 32'h2);
      rd(ra(0, 0, 0), p, OK);
    end
  endtask
  task t_wrap;
    begin
      wr(ra(0, 0, 2), 32'hfffffffc, OK);
      rq(0, 0, 2, 0, 1, 0, 32'h8, 32'hfffffffc);
      rd(ra(0, 0, 2), 32'h4, OK);
      wr(ra(1, 1, 2), 32'h10, OK);
      wr(ra(0, 1, 2), 32'h1000, OK);
      wr(ra(1, 0, 1), 32'hfffff8, OK);
      rq(1, 0, 1, 2, 0, 0, 32'h0, 32'hfffff8);
      rd(ra(1, 0, 1), 32'h8, OK);
      rq(1, 0, 1, 0, 1, 0, 32'hfffffe, 32'h8);
      rd(ra(1, 0, 1), 32'h6, OK);
    end
  endtask
  task t_bank;
    integer    k;
    reg [11:0] a;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        a = ra(k >= 2, 2'h1, (k % 2) ? 3'h1 : 3'h5);
        wr(a, 32'h11 + k, OK);
        wr(`DAG_MODE_OFFSET, 32'h8 << k, OK);
        rd(`DAG_MODE_OFFSET, 32'h8 << k, OK);
        rd(a, 32'h0, OK);
        wr(a, 32'h77, OK);
        rd(a, 32'h77, OK);
        wr(`DAG_MODE_OFFSET, 32'h0, OK);
        rd(a, 32'h11 + k, OK);
      end
    end
  endtask
  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = 0;
    err_total = 0;
    cmp_count = 0;
    slow = 1'b0;
    wstrb = 4'hf;
    cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reg;
    t_circ;
    t_wrap;
    slow = 1'b1;
    t_bank;
    give_verdict;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
endmodule
bind dual_data_address_generator dag_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .dm_req_valid(dm_req_valid), .dm_req_pre(dm_req_pre),
  .dm_req_ptr(dm_req_ptr), .dm_req_use_imm(dm_req_use_imm), .dm_req_short(dm_req_short),
  .dm_req_imm(dm_req_imm), .dm_addr(dm_addr), .dm_addr_valid(dm_addr_valid),
  .pm_req_valid(pm_req_valid), .pm_addr_valid(pm_addr_valid));
